// *** core/analyzer_cfg_pkg.sv ***
// analyzer_cfg_pkg: register numbers, field positions, limits and reset
// values of the analyzer configuration words.
// assumes a 16-bit word register port addressed by register number.
package analyzer_cfg_pkg;

  // register numbers on the word port
  localparam logic [15:0] ADDR_ALARM_CONFIG = 16'h0004;
  localparam logic [15:0] ADDR_ANALOG_OUTPUT_CONFIG = 16'h0005;
  localparam logic [15:0] ADDR_TIME_OF_DAY = 16'h0006;
  localparam logic [15:0] ADDR_CALENDAR_DATE = 16'h0007;
  localparam logic [15:0] ADDR_FAULT_SOURCE_MASK = 16'h0009;
  localparam logic [15:0] ADDR_FLOAT_HIGH = 16'h000a;
  localparam logic [15:0] ADDR_FLOAT_LOW = 16'h000b;

  // alarm configuration word
  localparam int ALARM_ONE_LSB = 0;
  localparam int ALARM_TWO_LSB = 4;
  localparam int ALARM_THREE_LSB = 8;
  localparam int LATCH_LSB = 12;

  // analog output configuration word
  localparam int OUT_ONE_LSB = 0;
  localparam int OUT_TWO_LSB = 4;
  localparam int TYPE_ONE_BIT = 8;
  localparam int TYPE_TWO_BIT = 9;
  localparam logic [15:0] ANALOG_USED_MASK = 16'h03ff;

  // time and date words
  localparam int HOUR_LSB = 8;
  localparam int MINUTE_LSB = 0;
  localparam int DAY_LSB = 11;
  localparam int MONTH_LSB = 7;
  localparam int YEAR_LSB = 0;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] MINUTE_MAX = 8'h3b;
  localparam logic [4:0] DAY_MIN = 5'h01;
  localparam logic [3:0] MONTH_MIN = 4'h1;
  localparam logic [3:0] MONTH_MAX = 4'hc;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [6:0] SECONDS_MAX = 7'h3b;

  // single precision float layout
  localparam int FLOAT_SIGN_BIT = 31;
  localparam int FLOAT_EXP_LSB = 23;
  localparam int FLOAT_FRAC_W = 23;
  localparam logic signed [8:0] FLOAT_BIAS = 9'sh07f;

  typedef enum logic [3:0] {
    PARAM_PPMV = 4'h0,
    PARAM_PPMW = 4'h1,
    PARAM_MGM3 = 4'h2,
    PARAM_WVP = 4'h3,
    PARAM_LBMMSCF = 4'h4,
    PARAM_DEW_POINT = 4'h5,
    PARAM_OVEN_TEMP = 4'h6,
    PARAM_FLOW_RATE = 4'h7,
    PARAM_CELL_PRESSURE = 4'h8,
    PARAM_LINE_PRESSURE = 4'h9
  } param_code_t;

  typedef enum logic {
    OUT_CURRENT_LOOP = 1'b0,
    OUT_VOLTAGE = 1'b1
  } output_type_t;

  // reset values
  localparam logic [15:0] ALARM_CONFIG_RESET = 16'h0060;
  localparam logic [15:0] ANALOG_OUTPUT_RESET = 16'h0050;
  localparam logic [15:0] TIME_OF_DAY_RESET = 16'h0000;
  localparam logic [15:0] CALENDAR_DATE_RESET = 16'h0880;
  localparam logic [15:0] FAULT_MASK_RESET = 16'h0000;
  localparam logic [31:0] FLOAT_RESET = 32'h0000_0000;

  function automatic logic sel_valid(input logic [3:0] code);
    return code <= PARAM_LINE_PRESSURE;
  endfunction : sel_valid

endpackage : analyzer_cfg_pkg

// *** core/analyzer_config_regs.sv ***
// analyzer_config_regs: configuration word bank of the analyzer, reached
// by register number over a simple 16-bit word port.
// assumes one-cycle read and write strobes synchronous to i_clk.
//
// Overview of operation
// RULE1: the alarm-3 selector is a 4-bit code 0000..1001 naming the measured quantity.
// RULE2: each of the four latch-enable bits latches its alarm at 1 and not at 0.
// RULE3: alarm 4 has no selector in the alarm word; its sources come from a separate mask.
// RULE4: analog word holds ch1 selector in 3:0, ch2 in 7:4, ch1 type at 8, ch2 type at 9.
// RULE5: output selectors use codes 0000..1001, defaulting to 0000 for ch1 and 0101 for ch2.
// RULE6: a type bit of 0 picks a 4-20 mA loop and 1 picks 1-5 V, first for ch1, second for ch2.
// RULE7: the time word holds hours 00..23 in 15:8 and minutes 00..59 in 7:0.
// RULE8: floats are single precision with sign at 31, exponent biased 127 in 30:23, fraction 22:0.
// RULE9: a float spans two registers, the high half at the lower register number.
// RULE10: the date word holds day 1..31 in 15:11 and month 1..12 in 10:7.
// RULE11: the date's low seven bits hold a year 00..99 or seconds 00..59.
// RULE12: bits 15:10 of the analog word read as zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module analyzer_config_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_date_low_is_seconds,
  output logic [15:0] o_rdata,
  output logic o_rd_valid,
  output logic o_write_refused,
  output logic [3:0] o_alarm_three_parameter,
  output logic [3:0] o_alarm_latch_enables,
  output logic [15:0] o_fault_source_mask,
  output logic [3:0] o_output_one_parameter,
  output logic [3:0] o_output_two_parameter,
  output logic o_output_one_type,
  output logic o_output_two_type,
  output logic [7:0] o_hour_count,
  output logic [7:0] o_minute_count,
  output logic [4:0] o_day_of_month,
  output logic [3:0] o_minute_or_month_count,
  output logic [6:0] o_year_or_seconds,
  output logic [31:0] o_float_value,
  output logic o_float_sign,
  output logic signed [8:0] o_float_exponent,
  output logic [22:0] o_float_fraction
);
  logic [15:0] alarm_q, alarm_d;
  logic [15:0] analog_q, analog_d;
  logic [15:0] time_q, time_d;
  logic [15:0] date_q, date_d;
  logic [15:0] mask_q, mask_d;
  logic [31:0] float_q, float_d;
  logic [15:0] stage_q, stage_d;
  logic [15:0] snap_q, snap_d;
  logic [15:0] rdata_q, rdata_d;
  logic rd_valid_q, rd_valid_d;
  logic refused_q, refused_d;
  logic alarm_ok, time_ok, date_ok;
  logic [6:0] low_limit;

  // whole-word acceptance: a bad field refuses the word, keeping the old value
  always_comb begin
    alarm_ok = analyzer_cfg_pkg::sel_valid(i_wdata[analyzer_cfg_pkg::ALARM_ONE_LSB +: 4])
      && analyzer_cfg_pkg::sel_valid(i_wdata[analyzer_cfg_pkg::ALARM_TWO_LSB +: 4])
      && analyzer_cfg_pkg::sel_valid(i_wdata[analyzer_cfg_pkg::ALARM_THREE_LSB +: 4]); // [RULE1]
    time_ok = (i_wdata[analyzer_cfg_pkg::HOUR_LSB +: 8] <= analyzer_cfg_pkg::HOUR_MAX)
      && (i_wdata[analyzer_cfg_pkg::MINUTE_LSB +: 8] <= analyzer_cfg_pkg::MINUTE_MAX); // [RULE7]
    low_limit = i_date_low_is_seconds ? analyzer_cfg_pkg::SECONDS_MAX
                                      : analyzer_cfg_pkg::YEAR_MAX; // [RULE11]
    date_ok = (i_wdata[analyzer_cfg_pkg::DAY_LSB +: 5] >= analyzer_cfg_pkg::DAY_MIN)
      && (i_wdata[analyzer_cfg_pkg::MONTH_LSB +: 4] >= analyzer_cfg_pkg::MONTH_MIN)
      && (i_wdata[analyzer_cfg_pkg::MONTH_LSB +: 4] <= analyzer_cfg_pkg::MONTH_MAX)
      && (i_wdata[analyzer_cfg_pkg::YEAR_LSB +: 7] <= low_limit); // [RULE10] [RULE11]
  end

  always_comb begin
    alarm_d = alarm_q;
    analog_d = analog_q;
    time_d = time_q;
    date_d = date_q;
    mask_d = mask_q;
    float_d = float_q;
    stage_d = stage_q;
    snap_d = snap_q;
    refused_d = 1'b0;
    if (i_wr) begin
      unique case (i_addr)
        analyzer_cfg_pkg::ADDR_ALARM_CONFIG: begin
          if (alarm_ok) alarm_d = i_wdata; // [RULE1] [RULE2]
          else refused_d = 1'b1;
        end
        analyzer_cfg_pkg::ADDR_ANALOG_OUTPUT_CONFIG: begin
          if (analyzer_cfg_pkg::sel_valid(i_wdata[analyzer_cfg_pkg::OUT_ONE_LSB +: 4])
              && analyzer_cfg_pkg::sel_valid(i_wdata[analyzer_cfg_pkg::OUT_TWO_LSB +: 4]))
            analog_d = i_wdata & analyzer_cfg_pkg::ANALOG_USED_MASK; // [RULE5] [RULE12]
          else refused_d = 1'b1;
        end
        analyzer_cfg_pkg::ADDR_TIME_OF_DAY: begin
          if (time_ok) time_d = i_wdata; // [RULE7]
          else refused_d = 1'b1;
        end
        analyzer_cfg_pkg::ADDR_CALENDAR_DATE: begin
          if (date_ok) date_d = i_wdata; // [RULE10] [RULE11]
          else refused_d = 1'b1;
        end
        // alarm 4 sources live here, not in the alarm word
        analyzer_cfg_pkg::ADDR_FAULT_SOURCE_MASK: mask_d = i_wdata; // [RULE3]
        // high half waits in a stage so the pair commits as one value
        analyzer_cfg_pkg::ADDR_FLOAT_HIGH: stage_d = i_wdata; // [RULE9]
        analyzer_cfg_pkg::ADDR_FLOAT_LOW: float_d = {stage_q, i_wdata}; // [RULE9]
        default: refused_d = 1'b1;
      endcase
    end
    // reading the high half freezes the low half against a tear
    if (i_rd && i_addr == analyzer_cfg_pkg::ADDR_FLOAT_HIGH) snap_d = float_q[15:0]; // [RULE9]
  end

  always_comb begin
    rd_valid_d = i_rd;
    rdata_d = rdata_q;
    if (i_rd) begin
      unique case (i_addr)
        analyzer_cfg_pkg::ADDR_ALARM_CONFIG: rdata_d = alarm_q;
        analyzer_cfg_pkg::ADDR_ANALOG_OUTPUT_CONFIG: rdata_d = analog_q; // [RULE12]
        analyzer_cfg_pkg::ADDR_TIME_OF_DAY: rdata_d = time_q;
        analyzer_cfg_pkg::ADDR_CALENDAR_DATE: rdata_d = date_q;
        analyzer_cfg_pkg::ADDR_FAULT_SOURCE_MASK: rdata_d = mask_q;
        analyzer_cfg_pkg::ADDR_FLOAT_HIGH: rdata_d = float_q[31:16]; // [RULE9]
        analyzer_cfg_pkg::ADDR_FLOAT_LOW: rdata_d = snap_q; // [RULE9]
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      alarm_q <= analyzer_cfg_pkg::ALARM_CONFIG_RESET;
      analog_q <= analyzer_cfg_pkg::ANALOG_OUTPUT_RESET; // [RULE5]
      time_q <= analyzer_cfg_pkg::TIME_OF_DAY_RESET;
      date_q <= analyzer_cfg_pkg::CALENDAR_DATE_RESET;
      mask_q <= analyzer_cfg_pkg::FAULT_MASK_RESET;
      float_q <= analyzer_cfg_pkg::FLOAT_RESET;
      stage_q <= 16'h0000;
      snap_q <= 16'h0000;
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      analog_q <= analog_d;
      time_q <= time_d;
      date_q <= date_d;
      mask_q <= mask_d;
      float_q <= float_d;
      stage_q <= stage_d;
      snap_q <= snap_d;
      rdata_q <= rdata_d;
      rd_valid_q <= rd_valid_d;
      refused_q <= refused_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rd_valid = rd_valid_q;
  assign o_write_refused = refused_q;
  assign o_alarm_three_parameter = alarm_q[analyzer_cfg_pkg::ALARM_THREE_LSB +: 4]; // [RULE1]
  assign o_alarm_latch_enables = alarm_q[analyzer_cfg_pkg::LATCH_LSB +: 4]; // [RULE2]
  assign o_fault_source_mask = mask_q;
  assign o_output_one_parameter = analog_q[analyzer_cfg_pkg::OUT_ONE_LSB +: 4]; // [RULE4]
  assign o_output_two_parameter = analog_q[analyzer_cfg_pkg::OUT_TWO_LSB +: 4]; // [RULE4]
  assign o_output_one_type = analog_q[analyzer_cfg_pkg::TYPE_ONE_BIT]; // [RULE4] [RULE6]
  assign o_output_two_type = analog_q[analyzer_cfg_pkg::TYPE_TWO_BIT]; // [RULE4] [RULE6]
  assign o_hour_count = time_q[analyzer_cfg_pkg::HOUR_LSB +: 8];
  assign o_minute_count = time_q[analyzer_cfg_pkg::MINUTE_LSB +: 8];
  assign o_day_of_month = date_q[analyzer_cfg_pkg::DAY_LSB +: 5];
  assign o_minute_or_month_count = date_q[analyzer_cfg_pkg::MONTH_LSB +: 4];
  assign o_year_or_seconds = date_q[analyzer_cfg_pkg::YEAR_LSB +: 7];
  assign o_float_value = float_q;

  float_field_split u_float_split (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_value(float_q),
    .o_sign(o_float_sign),
    .o_exponent_field(),
    .o_exponent_unbiased(o_float_exponent),
    .o_fraction(o_float_fraction)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_alarm_three_range: assert property (o_alarm_three_parameter <= 4'h9) // [RULE1]
    else $error("alarm three selector out of range");
  chk_alarm_bad_refused: assert property (i_wr && i_addr == 16'h0004 && i_wdata[11:8] > 4'h9
    |=> $stable(alarm_q) && o_write_refused) // [RULE1]
    else $error("bad alarm selector accepted");
  chk_latch_follows_write: assert property (i_wr && i_addr == 16'h0004 && alarm_ok
    |=> o_alarm_latch_enables == $past(i_wdata[15:12])) // [RULE2]
    else $error("latch enables not taken from bits 15:12");
  chk_mask_separate: assert property (i_wr && i_addr == 16'h0009
    |=> o_fault_source_mask == $past(i_wdata) && $stable(alarm_q)) // [RULE3]
    else $error("fault mask write disturbed alarm word");
  chk_analog_fields: assert property (i_wr && i_addr == 16'h0005 && i_wdata[7:4] <= 4'h9
    && i_wdata[3:0] <= 4'h9 |=> o_output_two_parameter == $past(i_wdata[7:4])
    && o_output_two_type == $past(i_wdata[9]) && o_output_one_type == $past(i_wdata[8])) // [RULE4]
    else $error("analog field placement wrong");
  chk_output_defaults: assert property ($past(!i_rst_n) |-> o_output_one_parameter == 4'h0
    && o_output_two_parameter == 4'h5 && !o_output_one_type) // [RULE5]
    else $error("analog defaults wrong after reset");
  chk_analog_upper_zero: assert property (i_rd && i_addr == 16'h0005
    |=> o_rd_valid && o_rdata[15:10] == 6'h00) // [RULE12]
    else $error("analog upper bits not zero");
  chk_time_range: assert property (o_hour_count <= 8'd23 && o_minute_count <= 8'd59) // [RULE7]
    else $error("time word out of range");
  chk_date_range: assert property (o_day_of_month >= 5'd1 && o_minute_or_month_count >= 4'd1
    && o_minute_or_month_count <= 4'd12) // [RULE10]
    else $error("date word out of range");
  chk_seconds_limit: assert property (i_wr && i_addr == 16'h0007 && i_date_low_is_seconds
    && i_wdata[6:0] > 7'd59 |=> $stable(date_q) ##1 $stable(date_q) || $past(i_wr)) // [RULE11]
    else $error("seconds above 59 accepted");
  chk_float_pair: assert property (i_wr && i_addr == 16'h000a ##1 i_wr && i_addr == 16'h000b
    |=> o_float_value == {$past(i_wdata, 2), $past(i_wdata)}) // [RULE9]
    else $error("float pair not high word first");

  cov_float_commit: cover property (i_wr && i_addr == 16'h000b ##2 o_float_sign);
  cov_time_refused: cover property (i_wr && i_addr == 16'h0006 ##1 o_write_refused);
  cov_latch_set: cover property (o_alarm_latch_enables == 4'hf);
  cov_voltage_out: cover property (o_output_one_type && o_output_two_type);

endmodule : analyzer_config_regs
`default_nettype wire

// *** core/float_field_split.sv ***
// float_field_split: registered split of a single precision word into
// sign, biased and unbiased exponent and fraction.
// assumes a synchronous active-low reset shared with the register bank.
`timescale 1ns/1ns
`default_nettype none
module float_field_split (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_value,
  output logic o_sign,
  output logic [7:0] o_exponent_field,
  output logic signed [8:0] o_exponent_unbiased,
  output logic [analyzer_cfg_pkg::FLOAT_FRAC_W-1:0] o_fraction
);
  logic sign_d;
  logic [7:0] exp_d;
  logic signed [8:0] unb_d;
  logic [analyzer_cfg_pkg::FLOAT_FRAC_W-1:0] frac_d;

  always_comb begin
    sign_d = i_value[analyzer_cfg_pkg::FLOAT_SIGN_BIT]; // [RULE8]
    exp_d = i_value[analyzer_cfg_pkg::FLOAT_EXP_LSB +: 8]; // [RULE8]
    unb_d = $signed({1'b0, exp_d}) - analyzer_cfg_pkg::FLOAT_BIAS; // [RULE8]
    frac_d = i_value[analyzer_cfg_pkg::FLOAT_FRAC_W-1:0]; // [RULE8]
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sign <= 1'b0;
      o_exponent_field <= 8'h00;
      o_exponent_unbiased <= 9'sh000;
      o_fraction <= '0;
    end else begin
      o_sign <= sign_d;
      o_exponent_field <= exp_d;
      o_exponent_unbiased <= unb_d;
      o_fraction <= frac_d;
    end
  end

  chk_float_exponent_bias: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_exponent_unbiased == $signed({1'b0, $past(i_value[30:23])}) - 9'sd127
      && o_sign == $past(i_value[31])) // [RULE8]
    else $error("float exponent not unbiased by 127");

endmodule : float_field_split
`default_nettype wire

// *** test/analyzer_config_regs_test.sv ***
// analyzer_config_regs_test: corner and random accesses on the config words.
// assumes reg_host drives the word port at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module analyzer_config_regs_test;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sec_mode = 1'b0;
  logic wr, rd, rd_valid, refused_p, t1, t2, fsign;
  logic [15:0] addr, wdata, rdata, mask, stage_hi, snap_lo, a, d;
  logic [3:0] a3, latch, p1, p2, month;
  logic [7:0] hour, minute;
  logic [4:0] day;
  logic [6:0] year;
  logic [31:0] fval, fl;
  logic signed [8:0] fexp;
  logic [22:0] ffrac;
  logic [15:0] mdl [16];
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [15:0] ADDRS [9] = '{16'h4, 16'h5, 16'h6, 16'h7, 16'h9, 16'ha, 16'hb,
    16'h3, 16'h8};
  localparam logic [32:0] CORNERS [16] = '{33'h0_0006_173b, 33'h0_0006_1800, 33'h0_0006_003c,
    33'h0_0006_0000, 33'h0_0007_fe63, 33'h1_0007_fe63, 33'h1_0007_08bb, 33'h0_0007_0080,
    33'h0_0007_fe81, 33'h0_0005_ffff, 33'h0_0005_fc99, 33'h0_0004_f900, 33'h0_0004_f0a9,
    33'h0_0009_ffff, 33'h0_0003_1234, 33'h0_000c_0000};

  always #25 i_clk = ~i_clk;

  analyzer_config_regs u_analyzer_config_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_date_low_is_seconds(sec_mode),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_write_refused(refused_p),
    .o_alarm_three_parameter(a3), .o_alarm_latch_enables(latch), .o_fault_source_mask(mask),
    .o_output_one_parameter(p1), .o_output_two_parameter(p2), .o_output_one_type(t1),
    .o_output_two_type(t2), .o_hour_count(hour), .o_minute_count(minute),
    .o_day_of_month(day), .o_minute_or_month_count(month), .o_year_or_seconds(year),
    .o_float_value(fval), .o_float_sign(fsign), .o_float_exponent(fexp),
    .o_float_fraction(ffrac));
  reg_host u_reg_host (.i_clk(i_clk), .i_rd_valid(rd_valid), .i_write_refused(refused_p),
    .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  function automatic logic legal(input logic [15:0] x, input logic [15:0] v, input logic s);
    case (x)
      16'h0004: return v[3:0] <= 4'h9 && v[7:4] <= 4'h9 && v[11:8] <= 4'h9;
      16'h0005: return v[3:0] <= 4'h9 && v[7:4] <= 4'h9;
      16'h0006: return v[15:8] <= 8'h17 && v[7:0] <= 8'h3b;
      16'h0007: return v[15:11] != 5'h00 && v[10:7] != 4'h0 && v[10:7] <= 4'hc
        && v[6:0] <= (s ? 7'h3b : 7'h63);
      16'h0009, 16'h000a, 16'h000b: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : legal

  task automatic check_word(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: word %h, want %h", $time, got, want);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic want);
    checks_done++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, want);
    end
  endtask : check_flag

  task automatic check_fields();
    check_word({a3, latch}, {mdl[4][11:8], mdl[4][15:12]});
    check_word(mask, mdl[9]);
    check_word({t2, t1, p2, p1}, mdl[5][9:0]);
    check_word({hour, minute}, mdl[6]);
    check_word({day, month, year}, mdl[7]);
    check_word(fval, fl);
    check_word({fsign, ffrac}, {fl[31], fl[22:0]});
    check_word({23'h0, fexp}, {23'h0, 9'({1'b0, fl[30:23]} - 9'd127)});
  endtask : check_fields

  task automatic access(input logic [15:0] x, input logic [15:0] v);
    logic r, ok;
    logic [15:0] q;
    ok = legal(x, v, sec_mode);
    u_reg_host.write_word(x, v, r);
    check_flag(r, !ok);
    if (ok && x == 16'h000a) stage_hi = v;
    else if (ok && x == 16'h000b) fl = {stage_hi, v};
    else if (ok) mdl[x[3:0]] = (x == 16'h0005) ? (v & 16'h03ff) : v;
    u_reg_host.read_word(x, q, r);
    check_flag(r, 1'b1);
    if (x == 16'h000a) snap_lo = fl[15:0];
    check_word(q, x == 16'h000a ? fl[31:16] : x == 16'h000b ? snap_lo : mdl[x[3:0]]);
    check_fields();
  endtask : access

  task automatic do_reset();
    i_rst_n = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[4] = 16'h0060;
    mdl[5] = 16'h0050;
    mdl[7] = 16'h0880;
    fl = 32'h0000_0000;
    @(negedge i_clk);
    check_fields();
    access(16'h000a, 16'h3f80);
    $display("test reset done");
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(51669));
    do_reset();
    foreach (CORNERS[i]) begin
      sec_mode = CORNERS[i][32];
      access(CORNERS[i][31:16], CORNERS[i][15:0]);
    end
    sec_mode = 1'b0;
    for (int c = 0; c < 16; c++) begin
      access(16'h0004, {4'(c), 4'(c), 8'h99});
      access(16'h0005, {6'h3f, 2'(c), 4'(c), 4'(15 - c)});
    end
    $display("test corners done");
    access(16'h000a, 16'h4124);
    access(16'h000b, 16'hcccd);
    check_word({23'h0, fexp}, 32'h0000_0003);
    u_reg_host.write_float(32'hb696feb5);
    stage_hi = 16'hb696;
    fl = 32'hb696feb5;
    @(negedge i_clk);
    check_fields();
    check_word({23'h0, fexp}, 32'h0000_01ee);
    access(16'h000b, 16'h1234);
    $display("test float done");
    repeat (2) begin
      repeat (150) begin
        a = ADDRS[$urandom % 9];
        d = 16'($urandom);
        if (a == 16'h0006) d = {8'($urandom % 26), 8'($urandom % 62)};
        if (a == 16'h0007) d[10:0] = {4'($urandom % 14), 7'($urandom % 104)};
        sec_mode = 1'($urandom);
        access(a, d);
      end
      do_reset();
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule : analyzer_config_regs_test
`default_nettype wire

// *** test/reg_host.sv ***
// reg_host: host side of the word register port, one strobe per access.
// assumes the block answers a read or refusal one cycle after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module reg_host (
  input wire logic i_clk,
  input wire logic i_rd_valid,
  input wire logic i_write_refused,
  input wire logic [15:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end

  // idle lines are scrambled so nothing can lean on stale values
  task automatic release_bus();
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
  endtask : release_bus

  task automatic write_word(input logic [15:0] a, input logic [15:0] d, output logic refused);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    release_bus();
    refused = i_write_refused;
  endtask : write_word

  task automatic read_word(input logic [15:0] a, output logic [15:0] q, output logic valid);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    release_bus();
    valid = i_rd_valid;
    q = i_rdata;
  endtask : read_word

  // high half first, at the lower register number; back to back so the
  // pair commits on consecutive strobes with no idle cycle between them
  task automatic write_float(input logic [31:0] value);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = analyzer_cfg_pkg::ADDR_FLOAT_HIGH;
    o_wdata = value[31:16];
    @(negedge i_clk);
    o_addr = analyzer_cfg_pkg::ADDR_FLOAT_LOW;
    o_wdata = value[15:0];
    @(negedge i_clk);
    release_bus();
  endtask : write_float
endmodule : reg_host
`default_nettype wire
